// File: shared/fsub_pkg.sv
// constants, field layouts and register map of the float subtract unit
package fsub_pkg;
  // extended-precision word: exponent, sign, fraction
  localparam int WORD_W = 40;
  localparam int EXP_HI = 39;
  localparam int EXP_LO = 32;
  localparam int SIGN_BIT = 31;
  localparam int FRAC_HI = 30;
  localparam int MANT_W = 32;
  localparam int INT_W = 32;
  localparam logic [7:0] ZERO_EXP = 8'h80;
  localparam logic [7:0] MAX_EXP = 8'h7F;
  localparam logic [30:0] MAX_FRAC = 31'h7FFF_FFFF;
  localparam logic signed [9:0] EXP_TOP = 10'sh07F;
  localparam logic signed [9:0] EXP_BOT = 10'sh381;
  localparam logic signed [9:0] SHIFT_MAX = 10'sh01F;
  // short float immediate: 4-bit exponent, sign, 11-bit fraction
  localparam int SIMM_EXP_HI = 15;
  localparam int SIMM_EXP_LO = 12;
  localparam int SIMM_SIGN = 11;
  localparam int SIMM_FRAC_HI = 10;
  localparam logic [3:0] SIMM_ZERO_EXP = 4'h8;
  localparam logic [19:0] SIMM_PAD = 20'h0_0000;
  // instruction fields
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 23;
  localparam int MODE_HI = 22;
  localparam int MODE_LO = 21;
  localparam int DST_HI = 20;
  localparam int DST_LO = 16;
  localparam int SRC_HI = 15;
  localparam int SRC_LO = 0;
  localparam logic [8:0] OPC_CSUB = 9'h02E;
  localparam logic [8:0] OPC_FSUB = 9'h02F;
  localparam logic [4:0] LOCAL_REGS = 5'h08;
  localparam int NREGS = 8;
  localparam int RIDX_W = 3;
  // source addressing modes, in field order 00..11
  typedef enum logic [1:0] {MODE_REG, MODE_DIRECT, MODE_INDIRECT, MODE_IMM} src_mode_t;
  // status bits
  localparam int ST_W = 7;
  localparam int ST_C = 0;
  localparam int ST_V = 1;
  localparam int ST_Z = 2;
  localparam int ST_N = 3;
  localparam int ST_UF = 4;
  localparam int ST_LV = 5;
  localparam int ST_LUF = 6;
  localparam logic [ST_W-1:0] ST_RESET = 7'h00;
  // interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_UNF = 2;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_REG_LO = 8'h40;
  localparam logic [7:0] ADDR_REG_HI = 8'h60;
  localparam int CTRL_SAT = 0;
  // register port address split: window select and register index
  localparam int ASEL_HI = 7;
  localparam int ASEL_LO = 5;
  localparam int AIDX_HI = 4;
  localparam int AIDX_LO = 2;
endpackage : fsub_pkg

// File: shared/fsub_core_if.sv
// operand and result bundle between the unit and its float subtractor
`timescale 1ns/100ps
interface fsub_core_if;
  logic [fsub_pkg::WORD_W-1:0] minuend;
  logic [fsub_pkg::WORD_W-1:0] subtrahend;
  logic [fsub_pkg::WORD_W-1:0] diff;
  logic neg;
  logic zero;
  logic ovf;
  logic unf;
  modport core (input minuend, input subtrahend, output diff, output neg, output zero, output ovf, output unf);
  modport user (output minuend, output subtrahend, input diff, input neg, input zero, input ovf, input unf);
endinterface : fsub_core_if

// File: verilog/fsub_arith.sv
// combinational extended-precision float subtractor
`timescale 1ns/100ps
module fsub_arith (
  // operands in, difference and condition out
  fsub_core_if.core cif
);
  logic sa, sb, za, zb, swap, sg, ss, zs, sr, exact0;
  logic signed [9:0] ea, eb, eg, es, er, dexp;
  logic [31:0] ma, mb, mg, ms, msh, mr, mdiff;
  logic [32:0] msum;
  logic [9:0] lz;

  // unpack, order by magnitude, align, add or subtract, normalise
  always_comb begin
    ea = {{2{cif.minuend[fsub_pkg::EXP_HI]}}, cif.minuend[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO]};
    eb = {{2{cif.subtrahend[fsub_pkg::EXP_HI]}}, cif.subtrahend[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO]};
    sa = cif.minuend[fsub_pkg::SIGN_BIT];
    sb = ~cif.subtrahend[fsub_pkg::SIGN_BIT]; // subtract as add of negated source
    za = cif.minuend[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO] == fsub_pkg::ZERO_EXP;
    zb = cif.subtrahend[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO] == fsub_pkg::ZERO_EXP;
    ma = {1'b1, cif.minuend[fsub_pkg::FRAC_HI:0]};
    mb = {1'b1, cif.subtrahend[fsub_pkg::FRAC_HI:0]};
    swap = zb ? 1'b0 : (za ? 1'b1 : ((eb > ea) || ((eb == ea) && (mb > ma))));
    eg = swap ? eb : ea;
    es = swap ? ea : eb;
    mg = swap ? mb : ma;
    ms = swap ? ma : mb;
    sg = swap ? sb : sa;
    ss = swap ? sa : sb;
    zs = swap ? za : zb;
    dexp = eg - es;
    msh = (zs || (dexp > fsub_pkg::SHIFT_MAX)) ? '0 : (ms >> dexp[4:0]);
    msum = {1'b0, mg} + {1'b0, msh};
    mdiff = mg - msh;
    lz = '0;
    mr = '0;
    er = eg;
    sr = sg;
    exact0 = za && zb;
    if (sg == ss) begin
      mr = msum[32] ? msum[32:1] : msum[31:0];
      er = msum[32] ? (eg + 10'sh001) : eg;
    end else begin
      for (int i = 0; i < fsub_pkg::MANT_W; i++) begin
        if (mdiff[i]) begin
          lz = 10'(fsub_pkg::MANT_W - 1 - i);
        end
      end
      mr = mdiff << lz[4:0];
      er = eg - $signed(lz);
      exact0 = exact0 || (mdiff == '0);
    end
    cif.ovf = 1'b0;
    cif.unf = 1'b0;
    cif.zero = 1'b0;
    cif.neg = 1'b0;
    if (exact0) begin
      cif.diff = {fsub_pkg::ZERO_EXP, 32'h0000_0000};
      cif.zero = 1'b1;
    end else if (er > fsub_pkg::EXP_TOP) begin
      cif.diff = {fsub_pkg::MAX_EXP, sr, fsub_pkg::MAX_FRAC}; // saturate to largest
      cif.ovf = 1'b1;
      cif.neg = sr;
    end else if (er < fsub_pkg::EXP_BOT) begin
      cif.diff = {fsub_pkg::ZERO_EXP, 32'h0000_0000}; // flush to zero
      cif.unf = 1'b1;
      cif.zero = 1'b1;
    end else begin
      cif.diff = {er[7:0], sr, mr[fsub_pkg::FRAC_HI:0]};
      cif.neg = sr;
    end
  end
endmodule : fsub_arith

// File: verilog/float_subtract_unit.sv
// float subtract and conditional subtract execution datapath
`timescale 1ns/100ps
module float_subtract_unit #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction issue from the decoder
  input wire logic issue,
  input wire logic [31:0] instr,
  // operands fetched outside: memory or far source, far destination
  input wire logic [fsub_pkg::WORD_W-1:0] fetch_data,
  input wire logic [fsub_pkg::WORD_W-1:0] far_dst_data,
  // result to the register file
  output logic res_valid_r,
  output logic [4:0] res_dst_r,
  output logic [fsub_pkg::WORD_W-1:0] res_data_r,
  // status view
  output logic [fsub_pkg::ST_W-1:0] status_r,
  // register port
  input wire logic [fsub_pkg::ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata_r,
  // interrupt
  output logic irq_r
);

  // local register file R0..R7
  logic [fsub_pkg::WORD_W-1:0] regs_r [fsub_pkg::NREGS];
  logic [fsub_pkg::IRQ_W-1:0] irq_stat_r;
  logic [fsub_pkg::IRQ_W-1:0] irq_mask_r;
  logic saturate_mode_bit_r;

  // decoded instruction
  logic [8:0] opc;
  fsub_pkg::src_mode_t mode;
  logic [4:0] dst;
  logic [15:0] srcf;
  logic do_fsub;
  logic do_csub;
  logic do_any;
  logic dst_local;
  logic [fsub_pkg::WORD_W-1:0] src_val;
  logic [fsub_pkg::WORD_W-1:0] dst_val;
  logic [fsub_pkg::WORD_W-1:0] result;

  // conditional subtract datapath
  logic [fsub_pkg::INT_W:0] cdiff;
  logic csub_nonneg;
  logic [fsub_pkg::WORD_W-1:0] csub_res;

  // next values
  logic [fsub_pkg::ST_W-1:0] status_nxt;
  logic [fsub_pkg::IRQ_W-1:0] irq_ev;
  logic [fsub_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [fsub_pkg::IRQ_W-1:0] irq_mask_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [fsub_pkg::NREGS-1:0] ins_we;
  logic [fsub_pkg::NREGS-1:0] lo_we;
  logic [fsub_pkg::NREGS-1:0] hi_we;

  // float subtractor
  fsub_core_if cif ();

  fsub_arith u_arith (
    .cif(cif.core)
  );

  // register number held in this unit
  function automatic logic is_local(input logic [4:0] r);
    return r < fsub_pkg::LOCAL_REGS;
  endfunction : is_local

  // widen a short float immediate to the extended word
  function automatic logic [fsub_pkg::WORD_W-1:0] short_to_ext(input logic [15:0] s);
    logic [3:0] e;
    e = s[fsub_pkg::SIMM_EXP_HI:fsub_pkg::SIMM_EXP_LO];
    if (e == fsub_pkg::SIMM_ZERO_EXP) begin
      return {fsub_pkg::ZERO_EXP, 32'h0000_0000};
    end
    return {{4{e[3]}}, e, s[fsub_pkg::SIMM_SIGN], s[fsub_pkg::SIMM_FRAC_HI:0], fsub_pkg::SIMM_PAD};
  endfunction : short_to_ext

  // register port address inside the window that starts at b
  function automatic logic slot_hit(input logic [fsub_pkg::ADDR_W-1:0] a, input logic [fsub_pkg::ADDR_W-1:0] b);
    return a[fsub_pkg::ASEL_HI:fsub_pkg::ASEL_LO] == b[fsub_pkg::ASEL_HI:fsub_pkg::ASEL_LO];
  endfunction : slot_hit

  // register index carried by a register port address
  function automatic logic [fsub_pkg::RIDX_W-1:0] slot_idx(input logic [fsub_pkg::ADDR_W-1:0] a);
    return a[fsub_pkg::AIDX_HI:fsub_pkg::AIDX_LO];
  endfunction : slot_idx

  // instruction field split and opcode decode
  always_comb begin
    opc = instr[fsub_pkg::OPC_HI:fsub_pkg::OPC_LO];
    mode = fsub_pkg::src_mode_t'(instr[fsub_pkg::MODE_HI:fsub_pkg::MODE_LO]);
    dst = instr[fsub_pkg::DST_HI:fsub_pkg::DST_LO];
    srcf = instr[fsub_pkg::SRC_HI:fsub_pkg::SRC_LO];
    do_fsub = issue && (opc == fsub_pkg::OPC_FSUB);
    do_csub = issue && (opc == fsub_pkg::OPC_CSUB);
    do_any = do_fsub || do_csub;
    dst_local = is_local(dst);
  end

  // source selection by addressing mode
  always_comb begin
    case (mode)
      fsub_pkg::MODE_REG: begin
        src_val = is_local(srcf[4:0]) ? regs_r[srcf[fsub_pkg::RIDX_W-1:0]] : fetch_data;
      end
      fsub_pkg::MODE_DIRECT: begin
        src_val = fetch_data;
      end
      fsub_pkg::MODE_INDIRECT: begin
        src_val = fetch_data;
      end
      fsub_pkg::MODE_IMM: begin
        src_val = do_fsub ? short_to_ext(srcf) : {24'h00_0000, srcf};
      end
      default: begin
        src_val = fetch_data;
      end
    endcase
    dst_val = dst_local ? regs_r[dst[fsub_pkg::RIDX_W-1:0]] : far_dst_data;
  end

  // float subtract: destination minus source
  assign cif.minuend = dst_val;
  assign cif.subtrahend = src_val;

  // conditional subtract on unsigned low words, exponent byte kept
  always_comb begin
    cdiff = {1'b0, dst_val[fsub_pkg::INT_W-1:0]} - {1'b0, src_val[fsub_pkg::INT_W-1:0]};
    csub_nonneg = !cdiff[fsub_pkg::INT_W]; // no borrow: dst >= src unsigned
    if (csub_nonneg) begin
      csub_res = {dst_val[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO], cdiff[fsub_pkg::INT_W-2:0], 1'b1};
    end else begin
      csub_res = {dst_val[fsub_pkg::EXP_HI:fsub_pkg::EXP_LO], dst_val[fsub_pkg::INT_W-2:0], 1'b0};
    end
    result = do_fsub ? cif.diff : csub_res;
  end

  // status next value: software load first, instruction update on top
  always_comb begin
    status_nxt = status_r;
    if (wr && (addr == fsub_pkg::ADDR_STATUS)) begin
      status_nxt = wdata[fsub_pkg::ST_W-1:0];
    end
    if (do_fsub && dst_local) begin
      status_nxt[fsub_pkg::ST_UF] = cif.unf;
      status_nxt[fsub_pkg::ST_N] = cif.neg;
      status_nxt[fsub_pkg::ST_Z] = cif.zero;
      status_nxt[fsub_pkg::ST_V] = cif.ovf;
      status_nxt[fsub_pkg::ST_LUF] = status_nxt[fsub_pkg::ST_LUF] | cif.unf;
      status_nxt[fsub_pkg::ST_LV] = status_nxt[fsub_pkg::ST_LV] | cif.ovf;
    end
  end

  // status flags register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= fsub_pkg::ST_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // per-register write enables: instruction result, bus low word, bus exponent byte
  always_comb begin
    ins_we = '0;
    lo_we = '0;
    hi_we = '0;
    if (do_any && dst_local) begin
      ins_we[dst[fsub_pkg::RIDX_W-1:0]] = 1'b1;
    end
    if (wr && slot_hit(addr, fsub_pkg::ADDR_REG_LO)) begin
      lo_we[slot_idx(addr)] = 1'b1;
    end
    if (wr && slot_hit(addr, fsub_pkg::ADDR_REG_HI)) begin
      hi_we[slot_idx(addr)] = 1'b1;
    end
  end

  // register file: instruction write wins over a bus write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < fsub_pkg::NREGS; i++) begin
        regs_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < fsub_pkg::NREGS; i++) begin
        if (ins_we[i]) begin
          regs_r[i] <= result;
        end else if (lo_we[i]) begin
          regs_r[i][fsub_pkg::INT_W-1:0] <= wdata[fsub_pkg::INT_W-1:0];
        end else if (hi_we[i]) begin
          regs_r[i][fsub_pkg::EXP_HI:fsub_pkg::EXP_LO] <= wdata[fsub_pkg::EXP_HI-fsub_pkg::EXP_LO:0];
        end
      end
    end
  end

  // result port toward the register file, one pulse per instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_valid_r <= 1'b0;
      res_dst_r <= '0;
      res_data_r <= '0;
    end else begin
      res_valid_r <= do_any;
      if (do_any) begin
        res_dst_r <= dst;
        res_data_r <= result;
      end
    end
  end

  // interrupt events: set wins over write-one-to-clear
  always_comb begin
    irq_ev = '0;
    irq_ev[fsub_pkg::IRQ_DONE] = do_any;
    irq_ev[fsub_pkg::IRQ_OVF] = do_fsub && cif.ovf;
    irq_ev[fsub_pkg::IRQ_UNF] = do_fsub && cif.unf;
    irq_stat_nxt = irq_stat_r;
    if (wr && (addr == fsub_pkg::ADDR_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~wdata[fsub_pkg::IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_ev;
    irq_mask_nxt = irq_mask_r;
    if (wr && (addr == fsub_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_nxt = wdata[fsub_pkg::IRQ_W-1:0];
    end
  end

  // interrupt status, mask and line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // control register: mode bit stored and readable, steers nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      saturate_mode_bit_r <= 1'b0;
    end else if (wr && (addr == fsub_pkg::ADDR_CTRL)) begin
      saturate_mode_bit_r <= wdata[fsub_pkg::CTRL_SAT];
    end
  end

  // read decode
  always_comb begin
    rdata_nxt = '0;
    if (rd) begin
      if (addr == fsub_pkg::ADDR_STATUS) begin
        rdata_nxt[fsub_pkg::ST_W-1:0] = status_r;
      end else if (addr == fsub_pkg::ADDR_IRQ_STAT) begin
        rdata_nxt[fsub_pkg::IRQ_W-1:0] = irq_stat_r;
      end else if (addr == fsub_pkg::ADDR_IRQ_MASK) begin
        rdata_nxt[fsub_pkg::IRQ_W-1:0] = irq_mask_r;
      end else if (addr == fsub_pkg::ADDR_CTRL) begin
        rdata_nxt[fsub_pkg::CTRL_SAT] = saturate_mode_bit_r;
      end else if (slot_hit(addr, fsub_pkg::ADDR_REG_LO)) begin
        rdata_nxt[fsub_pkg::INT_W-1:0] = regs_r[slot_idx(addr)][fsub_pkg::INT_W-1:0];
      end else if (slot_hit(addr, fsub_pkg::ADDR_REG_HI)) begin
        rdata_nxt[fsub_pkg::EXP_HI-fsub_pkg::EXP_LO:0] = regs_r[slot_idx(addr)][fsub_pkg::EXP_HI:fsub_pkg::EXP_LO];
      end
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule : float_subtract_unit

// File: verif/fsub_unit_properties.sv
// port assertions and covers for the float subtract unit
`timescale 1ns/100ps
module fsub_unit_properties #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction side
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [fsub_pkg::WORD_W-1:0] fetch_data,
  input wire logic [fsub_pkg::WORD_W-1:0] far_dst_data,
  // results and status
  input wire logic res_valid_r,
  input wire logic [4:0] res_dst_r,
  input wire logic [fsub_pkg::WORD_W-1:0] res_data_r,
  input wire logic [fsub_pkg::ST_W-1:0] status_r,
  // register port and interrupt
  input wire logic [fsub_pkg::ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata_r,
  input wire logic irq_r
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic st_wr;
  logic fs_go;
  logic cs_go;
  logic fs_loc;
  // decoded issue and status write
  assign st_wr = wr && addr == fsub_pkg::ADDR_STATUS;
  assign fs_go = issue && instr[31:23] == fsub_pkg::OPC_FSUB;
  assign cs_go = issue && instr[31:23] == fsub_pkg::OPC_CSUB;
  assign fs_loc = fs_go && instr[20:16] < fsub_pkg::LOCAL_REGS;
  AST_ONE_CYCLE: assert property ((fs_go || cs_go) |=> res_valid_r)
    else $error("no result one cycle after issue");
  AST_NO_SPURIOUS: assert property (!(fs_go || cs_go) |=> !res_valid_r)
    else $error("result without issue");
  AST_DST_ECHO: assert property (fs_go |=> res_dst_r == $past(instr[20:16]))
    else $error("result destination wrong");
  AST_CARRY_HOLD: assert property (!st_wr |=> $stable(status_r[fsub_pkg::ST_C]))
    else $error("carry changed");
  AST_CSUB_FLAGS: assert property (cs_go && !st_wr |=> $stable(status_r))
    else $error("conditional subtract moved flags");
  AST_FAR_DST: assert property (fs_go && !fs_loc && !st_wr |=> $stable(status_r))
    else $error("flags moved for far destination");
  AST_LUF_HOLD: assert property (status_r[fsub_pkg::ST_LUF] && !st_wr |=> status_r[fsub_pkg::ST_LUF])
    else $error("latched underflow dropped");
  AST_LV_HOLD: assert property (status_r[fsub_pkg::ST_LV] && !st_wr |=> status_r[fsub_pkg::ST_LV])
    else $error("latched overflow dropped");
  AST_Z_EXP: assert property (fs_loc |=> status_r[fsub_pkg::ST_Z] == (res_data_r[39:32] == fsub_pkg::ZERO_EXP))
    else $error("zero flag disagrees with result");
  AST_N_SIGN: assert property (fs_loc |=> status_r[fsub_pkg::ST_N] == (res_data_r[31] && res_data_r[39:32] != 8'h80))
    else $error("negative flag disagrees with result");
  AST_UF_LUF: assert property (fs_loc |=> !status_r[fsub_pkg::ST_UF] || status_r[fsub_pkg::ST_LUF])
    else $error("underflow not latched");
  AST_V_LV: assert property (fs_loc |=> !status_r[fsub_pkg::ST_V] || status_r[fsub_pkg::ST_LV])
    else $error("overflow not latched");
  // main scenarios reached
  cover property (fs_loc ##1 status_r[fsub_pkg::ST_V]);
  cover property (fs_loc ##1 status_r[fsub_pkg::ST_UF]);
  cover property (cs_go ##1 irq_r);
endmodule : fsub_unit_properties

bind float_subtract_unit fsub_unit_properties #(.DATA_W(DATA_W)) u_fsub_unit_properties (.clk, .nrst, .issue,
  .instr, .fetch_data, .far_dst_data, .res_valid_r, .res_dst_r, .res_data_r, .status_r, .addr, .wdata, .wr, .rd,
  .rdata_r, .irq_r);

// File: verif/fetch_model.sv
// operand fetch and far register file model
`timescale 1ns/100ps
module fetch_model (
  // clock
  input wire logic clk,
  // instruction on issue
  input wire logic [31:0] instr,
  // table load
  input wire logic ld,
  input wire logic [3:0] ld_idx,
  input wire logic [39:0] ld_val,
  // operands to the unit
  output logic [39:0] fetch_data,
  output logic [39:0] far_dst_data
);
  logic [39:0] mem [16];
  logic [39:0] junk_r = 40'h00_0000_0000;
  // table load and a pattern that moves every cycle
  always @(posedge clk) begin
    junk_r <= {junk_r[38:0], ~junk_r[39]};
    if (ld) begin
      mem[ld_idx] <= ld_val;
    end
  end
  // memory only where the source is fetched, junk otherwise
  assign fetch_data = (instr[22:21] inside {2'b01, 2'b10} || (instr[22:21] == 2'b00 && instr[4:0] > 5'd7)) ?
    mem[instr[3:0]] : junk_r;
  assign far_dst_data = instr[20:16] > 5'd7 ? mem[instr[19:16]] : junk_r;
endmodule : fetch_model

// File: verif/float_subtract_unit_tb.sv
// self-checking bench for the float subtract unit
`timescale 1ns/100ps
module float_subtract_unit_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic issue = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ld = 1'b0;
  logic [31:0] instr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0] addr = 8'h00;
  logic [3:0] ld_idx = 4'h0;
  logic [39:0] ld_val = 40'h00_0000_0000;
  logic [39:0] fetch_data, far_dst_data, res_data_r;
  logic res_valid_r, irq_r, latched_underflow_flag, lv;
  logic [4:0] res_dst_r;
  logic [6:0] status_r, st0;
  logic [31:0] rdata_r, v, d, s;
  logic [7:0] e;
  int failures = 0;
  int checks_done = 0;
  // float cases: dst, src, result, flags {uf,n,z,v}
  logic [39:0] fa [6] = '{40'h07_33c0_0000, 40'h03_4c20_0000, 40'h07_33c0_0000, 40'h7f_7fff_ffff,
    40'h81_0000_0001, 40'h07_33c0_0000};
  logic [39:0] fb [6] = '{40'h07_0c80_0000, 40'h05_7b40_0000, 40'h07_33c0_0000, 40'h7f_ffff_ffff,
    40'h81_0000_0000, 40'h07_0c80_0000};
  logic [39:0] fr [6] = '{40'h05_1d00_0000, 40'h05_c838_0000, 40'h80_0000_0000, 40'h7f_7fff_ffff,
    40'h80_0000_0000, 40'h05_1d00_0000};
  logic [3:0] ff [6] = '{4'h0, 4'h4, 4'h2, 4'h1, 4'ha, 4'h0};
  logic [15:0] sfm [4] = '{16'h0002, 16'h0005, 16'h0005, 16'h1000};
  logic [39:0] mr [4] = '{40'h00_0000_0000, 40'h00_4000_0000, 40'h00_4000_0000, 40'h80_0000_0000};

  float_subtract_unit #(.DATA_W(32)) u_float_subtract_unit (.clk, .nrst, .issue, .instr, .fetch_data,
    .far_dst_data, .res_valid_r, .res_dst_r, .res_data_r, .status_r, .addr, .wdata, .wr, .rd, .rdata_r, .irq_r);
  fetch_model u_fetch_model (.clk, .instr, .ld, .ld_idx, .ld_val, .fetch_data, .far_dst_data);

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // one register write or read, read data kept in v
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata_r;
  endtask : bus

  task automatic load(input logic [3:0] i, input logic [39:0] x);
    @(posedge clk);
    ld <= 1'b1;
    ld_idx <= i;
    ld_val <= x;
    @(posedge clk);
    ld <= 1'b0;
  endtask : load

  task automatic set_reg(input logic [2:0] n, input logic [39:0] x);
    bus(1'b1, fsub_pkg::ADDR_REG_LO + {3'h0, n, 2'b00}, x[31:0]);
    bus(1'b1, fsub_pkg::ADDR_REG_HI + {3'h0, n, 2'b00}, {24'h00_0000, x[39:32]});
  endtask : set_reg

  task automatic go(input logic [8:0] op, input logic [1:0] m, input logic [4:0] dn, input logic [15:0] sf);
    @(posedge clk);
    issue <= 1'b1;
    instr <= {op, m, dn, sf};
    @(posedge clk);
    issue <= 1'b0;
    #1 check(res_valid_r, 1'b1);
    check(res_dst_r, dn);
  endtask : go

  function automatic logic [31:0] csub(input logic [31:0] dv, input logic [31:0] sv);
    return dv >= sv ? ((dv - sv) << 1) | 32'h0000_0001 : dv << 1;
  endfunction : csub

  // hang guard
  initial begin
    #100000;
    failures++;
    stop_test;
  end

  // main sequence
  initial begin
    void'($urandom(32'h0b44_a38f));
    latched_underflow_flag = 1'b0;
    lv = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, fsub_pkg::ADDR_STATUS, 32'h0000_0000);
    check(v, 40'h00_0000_0000);
    bus(1'b1, fsub_pkg::ADDR_STATUS, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) bus(1'b1, fsub_pkg::ADDR_CTRL, 32'h0000_0001);
      set_reg(3'd1, fa[i]);
      load(4'h0, fb[i]);
      go(fsub_pkg::OPC_FSUB, 2'b01, 5'd1, 16'h0000);
      latched_underflow_flag = latched_underflow_flag | ff[i][3];
      lv = lv | ff[i][0];
      check(status_r, {latched_underflow_flag, lv, ff[i], 1'b1});
      check(fr[i][39:32] == 8'h80 ? {res_data_r[39:32], 32'h0000_0000} : res_data_r, fr[i]);
      bus(1'b0, fsub_pkg::ADDR_REG_HI + 8'h04, 32'h0000_0000);
      check(v, {32'h0000_0000, fr[i][39:32]});
    end
    // far destination: result out, flags kept
    load(4'h9, fa[3]);
    load(4'h0, fb[3]);
    st0 = status_r;
    go(fsub_pkg::OPC_FSUB, 2'b01, 5'd9, 16'h0000);
    check(res_data_r, fr[3]);
    check(status_r, st0);
    // each source mode on 2.0
    set_reg(3'd2, 40'h00_0000_0000);
    load(4'h5, 40'hff_0000_0000);
    for (int m = 0; m < 4; m++) begin
      set_reg(3'd1, 40'h01_0000_0000);
      go(fsub_pkg::OPC_FSUB, 2'(m), 5'd1, sfm[m]);
      check(m == 3 ? {res_data_r[39:32], 32'h0000_0000} : res_data_r, mr[m]);
    end
    // register source above R7 comes from fetch: zero minus largest gives largest negative
    go(fsub_pkg::OPC_FSUB, 2'b00, 5'd1, 16'h0009);
    check(res_data_r, fb[3]);
    // random conditional subtracts with both saturate settings
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      s = i % 3 == 0 ? $urandom : (i % 3 == 1 ? d >> 1 : d);
      e = 8'($urandom);
      bus(1'b1, fsub_pkg::ADDR_CTRL, {31'h0000_0000, i[0]});
      set_reg(3'd3, {e, d});
      load(4'h0, {8'h00, s});
      st0 = status_r;
      go(fsub_pkg::OPC_CSUB, 2'b01, 5'd3, 16'h0000);
      check(res_data_r, {e, csub(d, s)});
      check(status_r, st0);
    end
    bus(1'b1, fsub_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    set_reg(3'd0, 40'h00_0000_07d0);
    go(fsub_pkg::OPC_CSUB, 2'b11, 5'd0, 16'h0bb8);
    check(res_data_r[31:0], 32'h0000_0fa0);
    set_reg(3'd0, 40'h00_0000_04f6);
    go(fsub_pkg::OPC_CSUB, 2'b11, 5'd0, 16'h0492);
    check(res_data_r[31:0], 32'h0000_00c9);
    check(irq_r, 1'b1);
    bus(1'b1, fsub_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    // interrupt status, mask and clear, unmapped read
    bus(1'b0, fsub_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    check(v, 40'h00_0000_0007);
    check(irq_r, 1'b0);
    bus(1'b1, fsub_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    bus(1'b0, fsub_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    check(v, 40'h00_0000_0002);
    check(irq_r, 1'b1);
    bus(1'b1, fsub_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    bus(1'b0, fsub_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    check(v, 40'h00_0000_0005);
    check(irq_r, 1'b0);
    bus(1'b0, 8'h10, 32'h0000_0000);
    check(v, 40'h00_0000_0000);
    bus(1'b1, fsub_pkg::ADDR_STATUS, 32'h0000_0000);
    check(status_r, 7'h00);
    stop_test;
  end
endmodule : float_subtract_unit_tb
